// ==== obt_defines.vh ====
// What this block does
// - capture clocks load port registers on rise
// - capture happens whatever enable and direction
// - enable high drives nothing, captures continue
// - direction picks driven port when enabled
// - a-output source low passes live b
// - a-output source high sends stored b
// - b-output source low passes live a
// - b-output source high sends stored a
// - never drive both ports at once
// - input port storable in its own register
// - disabled output keeps input capture working
// - opposite port follows enable, direction, selects
`ifndef OBT_DEFINES_VH
`define OBT_DEFINES_VH

`define OBT_DATA_W        8
`define OBT_FIFO_W        18
`define OBT_FIFO_DEPTH    2

`define OBT_ADDR_CTRL     8'h00
`define OBT_ADDR_STATUS   8'h04
`define OBT_ADDR_STORE_A  8'h08
`define OBT_ADDR_STORE_B  8'h0c
`define OBT_ADDR_EVENT    8'h10

`define OBT_CTRL_SW_CAP_A 0
`define OBT_CTRL_SW_CAP_B 1
`define OBT_CTRL_CLR_OVF  2

`define OBT_ST_A_DRIVEN   0
`define OBT_ST_B_DRIVEN   1
`define OBT_ST_LEVEL_LO   2
`define OBT_ST_LEVEL_HI   3
`define OBT_ST_OVERFLOW   4
`define OBT_ST_A_LOADED   5
`define OBT_ST_B_LOADED   6

`define OBT_EV_VALID      17

`endif

// ==== obt_transceiver.v ====
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "obt_defines.vh"

module obt_transceiver
(
    // clock and reset
    input  wire        CORE_CLK_IN,
    input  wire        RESET_N_IN,
    // apb slave
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [7:0]  PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output wire        PREADY_OUT,
    output reg  [31:0] PRDATA_OUT,
    output reg         PSLVERR_OUT,
    // control pins
    input  wire        DRIVE_EN_N_IN,
    input  wire        DIRECTION_IN,
    input  wire        A_OUT_SOURCE_SELECT_IN,
    input  wire        B_OUT_SOURCE_SELECT_IN,
    input  wire        A_SIDE_CAPTURE_CLOCK_IN,
    input  wire        B_SIDE_CAPTURE_CLOCK_IN,
    // port a
    input  wire [7:0]  PORT_A_IN,
    output reg  [7:0]  PORT_A_OUT,
    output reg         PORT_A_OE_OUT,
    // port b
    input  wire [7:0]  PORT_B_IN,
    output reg  [7:0]  PORT_B_OUT,
    output reg         PORT_B_OE_OUT,
    // capture event buffer
    output wire        CAPTURE_READY_OUT
);

    // two-stage synchronisers; first stage read only by second
    reg  [7:0] port_a_meta;
    reg  [7:0] port_a_sync;
    reg  [7:0] port_b_meta;
    reg  [7:0] port_b_sync;
    reg  [5:0] ctl_meta;
    reg  [5:0] ctl_sync;
    reg        clk_a_prev;
    reg        clk_b_prev;

    always @(posedge CORE_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            port_a_meta <= 8'h00;
            port_a_sync <= 8'h00;
            port_b_meta <= 8'h00;
            port_b_sync <= 8'h00;
            ctl_meta    <= 6'h01;
            ctl_sync    <= 6'h01;
            clk_a_prev  <= 1'b0;
            clk_b_prev  <= 1'b0;
        end
        else
        begin
            port_a_meta <= PORT_A_IN;
            port_a_sync <= port_a_meta;
            port_b_meta <= PORT_B_IN;
            port_b_sync <= port_b_meta;
            ctl_meta    <= {B_SIDE_CAPTURE_CLOCK_IN, A_SIDE_CAPTURE_CLOCK_IN, B_OUT_SOURCE_SELECT_IN,
                            A_OUT_SOURCE_SELECT_IN, DIRECTION_IN, DRIVE_EN_N_IN};
            ctl_sync    <= ctl_meta;
            clk_a_prev  <= ctl_sync[4];
            clk_b_prev  <= ctl_sync[5];
        end
    end

    wire drive_en_n   = ctl_sync[0];
    wire direction    = ctl_sync[1];
    wire a_out_source = ctl_sync[2];
    wire b_out_source = ctl_sync[3];

    // apb decode
    wire apb_setup  = PSEL_IN & ~PENABLE_IN;
    wire apb_access = PSEL_IN & PENABLE_IN;
    wire apb_wr     = apb_access & PWRITE_IN;
    wire apb_rd     = apb_access & ~PWRITE_IN;

    function addr_mapped;
        input [7:0] addr;
        begin
            addr_mapped = (addr == `OBT_ADDR_CTRL) || (addr == `OBT_ADDR_STATUS) ||
                          (addr == `OBT_ADDR_STORE_A) || (addr == `OBT_ADDR_STORE_B) ||
                          (addr == `OBT_ADDR_EVENT);
        end
    endfunction

    wire ctrl_wr  = apb_wr & (PADDR_IN == `OBT_ADDR_CTRL);
    wire sw_cap_a = ctrl_wr & PWDATA_IN[`OBT_CTRL_SW_CAP_A];
    wire sw_cap_b = ctrl_wr & PWDATA_IN[`OBT_CTRL_SW_CAP_B];
    wire clr_ovf  = ctrl_wr & PWDATA_IN[`OBT_CTRL_CLR_OVF];

    // capture never gated by enable, direction or selects
    // pins are sampled by the core clock, so a capture pulse shorter
    // than one cycle high and one low can be missed
    wire cap_a = (ctl_sync[4] & ~clk_a_prev) | sw_cap_a;
    wire cap_b = (ctl_sync[5] & ~clk_b_prev) | sw_cap_b;

    // storage has no reset on purpose
    // stored data is undefined until its first capture; reads show zero until then
    reg  [7:0] store_a;
    reg  [7:0] store_b;
    reg        a_loaded;
    reg        b_loaded;

    always @(posedge CORE_CLK_IN)
    begin
        if (cap_a)
        begin
            store_a <= port_a_sync;
        end
        if (cap_b)
        begin
            store_b <= port_b_sync;
        end
    end

    // loaded flags let software see when stored data becomes meaningful
    always @(posedge CORE_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            a_loaded <= 1'b0;
            b_loaded <= 1'b0;
        end
        else
        begin
            a_loaded <= a_loaded | cap_a;
            b_loaded <= b_loaded | cap_b;
        end
    end

    // port drive; enables exclusive by construction
    // a direction flip swaps both enables at one edge, so they never overlap
    reg [7:0] next_port_a;
    reg [7:0] next_port_b;
    reg       next_a_oe;
    reg       next_b_oe;

    always @*
    begin
        next_a_oe   = ~drive_en_n & ~direction;
        next_b_oe   = ~drive_en_n & direction;
        next_port_a = a_out_source ? store_b : port_b_sync;
        next_port_b = b_out_source ? store_a : port_a_sync;
    end

    always @(posedge CORE_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            PORT_A_OUT    <= 8'h00;
            PORT_B_OUT    <= 8'h00;
            PORT_A_OE_OUT <= 1'b0;
            PORT_B_OE_OUT <= 1'b0;
        end
        else
        begin
            PORT_A_OUT    <= next_a_oe ? next_port_a : 8'h00;
            PORT_B_OUT    <= next_b_oe ? next_port_b : 8'h00;
            PORT_A_OE_OUT <= next_a_oe;
            PORT_B_OE_OUT <= next_b_oe;
        end
    end

    // two-entry buffer of capture events; apb reads drain it
    reg  [`OBT_FIFO_W-1:0] fifo_mem [0:`OBT_FIFO_DEPTH-1];
    reg                    fifo_wr_ptr;
    reg                    fifo_rd_ptr;
    reg  [1:0]             fifo_level;
    reg                    overflow;
    reg                    event_armed;

    wire fifo_in_valid  = cap_a | cap_b;
    wire fifo_in_ready  = (fifo_level != 2'd2);
    wire fifo_out_valid = (fifo_level != 2'd0);
    wire event_sel      = (PADDR_IN == `OBT_ADDR_EVENT);
    wire fifo_out_ready = apb_rd & event_sel & event_armed;
    wire fifo_push      = fifo_in_valid & fifo_in_ready;
    wire fifo_pop       = fifo_out_valid & fifo_out_ready;
    wire [`OBT_FIFO_W-1:0] fifo_in_word = {cap_b, cap_a,
                                           (cap_b ? port_b_sync : 8'h00),
                                           (cap_a ? port_a_sync : 8'h00)};

    assign CAPTURE_READY_OUT = fifo_in_ready;

    // a read of the event word pops only what its setup cycle latched;
    // an event that lands between setup and access waits for the next read
    wire event_rd_setup = apb_setup & ~PWRITE_IN & event_sel;

    always @(posedge CORE_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            event_armed <= 1'b0;
        end
        else if (apb_setup)
        begin
            event_armed <= event_rd_setup & fifo_out_valid;
        end
    end

    // a full buffer refuses a push even when a pop lands in the same cycle

    always @(posedge CORE_CLK_IN)
    begin
        if (fifo_push)
        begin
            fifo_mem[fifo_wr_ptr] <= fifo_in_word;
        end
    end

    always @(posedge CORE_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            fifo_wr_ptr <= 1'b0;
            fifo_rd_ptr <= 1'b0;
            fifo_level  <= 2'd0;
            overflow    <= 1'b0;
        end
        else
        begin
            if (fifo_push)
            begin
                fifo_wr_ptr <= ~fifo_wr_ptr;
            end
            if (fifo_pop)
            begin
                fifo_rd_ptr <= ~fifo_rd_ptr;
            end
            case ({fifo_push, fifo_pop})
                2'b10:   fifo_level <= fifo_level + 2'd1;
                2'b01:   fifo_level <= fifo_level - 2'd1;
                default: fifo_level <= fifo_level;
            endcase
            // a lost event wins over a clear in the same cycle
            if (fifo_in_valid & ~fifo_in_ready)
            begin
                overflow <= 1'b1;
            end
            else if (clr_ovf)
            begin
                overflow <= 1'b0;
            end
        end
    end

    // read data latched in setup, so access completes with no wait
    reg [31:0] next_rdata;

    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (PADDR_IN)
            `OBT_ADDR_STATUS:
            begin
                next_rdata[`OBT_ST_A_DRIVEN] = PORT_A_OE_OUT;
                next_rdata[`OBT_ST_B_DRIVEN] = PORT_B_OE_OUT;
                next_rdata[`OBT_ST_LEVEL_HI:`OBT_ST_LEVEL_LO] = fifo_level;
                next_rdata[`OBT_ST_OVERFLOW] = overflow;
                next_rdata[`OBT_ST_A_LOADED] = a_loaded;
                next_rdata[`OBT_ST_B_LOADED] = b_loaded;
            end
            `OBT_ADDR_STORE_A: next_rdata[7:0] = a_loaded ? store_a : 8'h00;
            `OBT_ADDR_STORE_B: next_rdata[7:0] = b_loaded ? store_b : 8'h00;
            `OBT_ADDR_EVENT:
            begin
                if (fifo_out_valid)
                begin
                    next_rdata[`OBT_FIFO_W-1:0] = fifo_mem[fifo_rd_ptr];
                end
            end
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge CORE_CLK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            PRDATA_OUT  <= 32'h0000_0000;
            PSLVERR_OUT <= 1'b0;
        end
        else if (apb_setup)
        begin
            PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : next_rdata;
            // unmapped writes change nothing; this flag is their only trace
            PSLVERR_OUT <= ~addr_mapped(PADDR_IN);
        end
    end

    assign PREADY_OUT = 1'b1;

endmodule

// ==== obt_props.sv ====
`timescale 1ns/1ps
module obt_props
(
    // pins
    input wire logic       CORE_CLK_IN,
    input wire logic       RESET_N_IN,
    input wire logic       DRIVE_EN_N_IN,
    input wire logic       DIRECTION_IN,
    input wire logic       A_OUT_SOURCE_SELECT_IN,
    input wire logic       B_OUT_SOURCE_SELECT_IN,
    input wire logic       A_SIDE_CAPTURE_CLOCK_IN,
    input wire logic       B_SIDE_CAPTURE_CLOCK_IN,
    input wire logic [7:0] PORT_A_IN,
    input wire logic [7:0] PORT_B_IN,
    // outputs
    input wire logic [7:0] PORT_A_OUT,
    input wire logic       PORT_A_OE_OUT,
    input wire logic [7:0] PORT_B_OUT,
    input wire logic       PORT_B_OE_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    wire drv_a = !DRIVE_EN_N_IN && !DIRECTION_IN;
    wire drv_b = !DRIVE_EN_N_IN && DIRECTION_IN;
    // five samples: two sync flops, output reg, sampling lag
    sequence live_a_s;
        (drv_a && !A_OUT_SOURCE_SELECT_IN && $stable(PORT_B_IN))[*5];
    endsequence
    sequence live_b_s;
        (drv_b && !B_OUT_SOURCE_SELECT_IN && $stable(PORT_A_IN))[*5];
    endsequence
    // six quiet samples let any earlier capture reach the output
    sequence keep_a_s;
        (drv_a && A_OUT_SOURCE_SELECT_IN && !B_SIDE_CAPTURE_CLOCK_IN)[*6];
    endsequence
    sequence keep_b_s;
        (drv_b && B_OUT_SOURCE_SELECT_IN && !A_SIDE_CAPTURE_CLOCK_IN)[*6];
    endsequence
    a_one_side: assert property (!(PORT_A_OE_OUT && PORT_B_OE_OUT))
        else $error("both ports driven");
    a_iso_quiet: assert property (DRIVE_EN_N_IN[*5] |-> !PORT_A_OE_OUT && !PORT_B_OE_OUT)
        else $error("port driven while isolated");
    a_dir_a: assert property (drv_a[*5] |-> PORT_A_OE_OUT && !PORT_B_OE_OUT)
        else $error("port a not driven");
    a_dir_b: assert property (drv_b[*5] |-> PORT_B_OE_OUT && !PORT_A_OE_OUT)
        else $error("port b not driven");
    a_live_a: assert property (live_a_s |-> PORT_A_OUT == PORT_B_IN)
        else $error("live b not on port a");
    a_live_b: assert property (live_b_s |-> PORT_B_OUT == PORT_A_IN)
        else $error("live a not on port b");
    a_stored_a: assert property (keep_a_s |-> $stable(PORT_A_OUT))
        else $error("port a moved without capture");
    a_stored_b: assert property (keep_b_s |-> $stable(PORT_B_OUT))
        else $error("port b moved without capture");
endmodule
bind obt_transceiver obt_props i_props
(
    .CORE_CLK_IN(CORE_CLK_IN), .RESET_N_IN(RESET_N_IN), .DRIVE_EN_N_IN(DRIVE_EN_N_IN),
    .DIRECTION_IN(DIRECTION_IN), .A_OUT_SOURCE_SELECT_IN(A_OUT_SOURCE_SELECT_IN),
    .B_OUT_SOURCE_SELECT_IN(B_OUT_SOURCE_SELECT_IN), .A_SIDE_CAPTURE_CLOCK_IN(A_SIDE_CAPTURE_CLOCK_IN),
    .B_SIDE_CAPTURE_CLOCK_IN(B_SIDE_CAPTURE_CLOCK_IN), .PORT_A_IN(PORT_A_IN), .PORT_B_IN(PORT_B_IN),
    .PORT_A_OUT(PORT_A_OUT), .PORT_A_OE_OUT(PORT_A_OE_OUT), .PORT_B_OUT(PORT_B_OUT),
    .PORT_B_OE_OUT(PORT_B_OE_OUT)
);

// ==== obt_bus_model.sv ====
`timescale 1ns/1ps
module obt_bus_model
(
    // device side
    input  wire logic       dev_oe_in,
    input  wire logic [7:0] dev_val_in,
    // far logic side
    input  wire logic [7:0] far_val_in,
    output wire logic [7:0] bus_level_out
);
    // far logic backs off while the device drives, so no contention
    assign bus_level_out = dev_oe_in ? dev_val_in : far_val_in;
endmodule

// ==== obt_transceiver_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module obt_transceiver_test;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        en_n = 1'b1, dir = 1'b0, asel = 1'b0, bsel = 1'b0, cka = 1'b0, ckb = 1'b0;
    logic        pready, pslverr, err, pa_oe, pb_oe, crdy;
    logic [7:0]  paddr = 8'h00, fa = 8'h00, fb = 8'h00, pa, pb, pa_out, pb_out;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          err_total = 0, tests_run = 0;
    always #5 clk = ~clk;
    obt_transceiver i_dut
    (
        .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
        .PSLVERR_OUT(pslverr), .DRIVE_EN_N_IN(en_n), .DIRECTION_IN(dir), .A_OUT_SOURCE_SELECT_IN(asel),
        .B_OUT_SOURCE_SELECT_IN(bsel), .A_SIDE_CAPTURE_CLOCK_IN(cka), .B_SIDE_CAPTURE_CLOCK_IN(ckb),
        .PORT_A_IN(pa), .PORT_A_OUT(pa_out), .PORT_A_OE_OUT(pa_oe), .PORT_B_IN(pb),
        .PORT_B_OUT(pb_out), .PORT_B_OE_OUT(pb_oe), .CAPTURE_READY_OUT(crdy)
    );
    obt_bus_model i_bus_a (.dev_oe_in(pa_oe), .dev_val_in(pa_out), .far_val_in(fa), .bus_level_out(pa));
    obt_bus_model i_bus_b (.dev_oe_in(pb_oe), .dev_val_in(pb_out), .far_val_in(fb), .bus_level_out(pb));
    task automatic wrap_up;
        $display("mismatches=%0d compares=%0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        for (n = 0; pready !== 1'b1; n++)
        begin
            if (n == 8)
            begin
                err_total++;
                wrap_up();
            end
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // c = {en_n, dir, asel, bsel, cka, ckb}; six edges cover the pin latency
    task automatic pins(input logic [5:0] c, input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        {en_n, dir, asel, bsel, cka, ckb} <= c;
        fa <= a;
        fb <= b;
        repeat (6) @(posedge clk);
        #1;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        pins(6'b100011, 8'h5a, 8'hc3);
        `CHK({pa_oe, pb_oe}, 2'b00)
        pins(6'b100000, 8'h11, 8'h22);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h0000005a)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(rd, 32'h000000c3)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd, 32'h0003c35a)
        apb(1'b1, 8'h40, 32'hffffffff);
        `CHK(err, 1'b1)
        pins(6'b010000, 8'h3c, 8'hc3);
        `CHK({pa_oe, pb_oe, pb_out}, {2'b01, 8'h3c})
        pins(6'b010100, 8'h3c, 8'h00);
        `CHK(pb_out, 8'h5a)
        pins(6'b010110, 8'h77, 8'h00);
        pins(6'b010100, 8'h77, 8'h00);
        `CHK(pb_out, 8'h77)
        pins(6'b000000, 8'h00, 8'h96);
        `CHK({pa_oe, pb_oe, pa_out}, {2'b10, 8'h96})
        pins(6'b001000, 8'h00, 8'h96);
        `CHK(pa_out, 8'hc3)
        pins(6'b001001, 8'h00, 8'h81);
        pins(6'b001000, 8'h00, 8'h81);
        `CHK(pa_out, 8'h81)
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h00000069)
        `CHK(crdy, 1'b0)
        pins(6'b001001, 8'h00, 8'h44);
        pins(6'b001000, 8'h00, 8'h44);
        `CHK(pa_out, 8'h44)
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h00000079)
        apb(1'b1, 8'h00, 32'h00000004);
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd, 32'h00010077)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd, 32'h00028100)
        apb(1'b0, 8'h04, 32'h0);
        `CHK({rd, crdy}, {32'h00000061, 1'b1})
        pins(6'b100000, 8'ha5, 8'h5b);
        apb(1'b1, 8'h00, 32'h00000003);
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h000000a5)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(rd, 32'h0000005b)
        wrap_up();
    end
endmodule
